// File: hdl/epw_pkg.sv
package epw_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CONFIG      = 8'h00;
    localparam logic [7:0]  OFS_SHUTDOWN    = 8'h04;
    localparam logic [7:0]  OFS_DEADBAND    = 8'h08;
    localparam logic [7:0]  OFS_STEERING    = 8'h0c;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CFG_SEL_LSB     = 6;
    localparam int          MODE_LSB        = 0;
    localparam int          SD_STATUS_BIT   = 7;
    localparam int          SD_SRC_LSB      = 4;
    localparam int          SAFE_A_LSB      = 2;
    localparam int          SAFE_B_LSB      = 0;
    localparam int          RESTART_BIT     = 7;
    localparam int          DB_COUNT_LSB    = 0;
    localparam int          STEER_SYNC_BIT  = 4;
    localparam int          STEER_B_BIT     = 1;
    localparam int          STEER_A_BIT     = 0;
    localparam int          SRC_CMP_BIT     = 0;
    localparam int          SRC_PIN_BIT     = 2;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_PWM        = 2'h3;
    localparam logic [1:0]  CFG_SINGLE      = 2'h0;
    localparam logic [1:0]  CFG_HALF        = 2'h2;
    localparam logic [7:0]  RST_CONFIG      = 8'h00;
    localparam logic [7:0]  RST_SHUTDOWN    = 8'h00;
    localparam logic [7:0]  RST_DEADBAND    = 8'h00;
    localparam logic [7:0]  RST_STEERING    = 8'h01;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        EPW_OFF  = 3'b001,
        EPW_WAIT = 3'b010,
        EPW_RUN  = 3'b100
    } epw_run_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic       req_d;
        logic       act;
    } epw_db_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_hold;
        logic              w_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rdata;
        logic [7:0]        config_r;
        logic [7:0]        shutdown_r;
        logic [7:0]        deadband_r;
        logic [7:0]        steering_r;
        logic [1:0]        steer_eff;
        logic              pin_s1;
        logic              pin_s2;
        logic              cmp_s1;
        logic              cmp_s2;
        epw_run_t          run;
        logic              out_a;
        logic              oe_a;
        logic              out_b;
        logic              oe_b;
    } epw_state_t;

endpackage

// File: hdl/epw_deadband.sv
`timescale 1ns/10ps
`default_nettype none

// Delays each rising request by a programmed number of cycles; falls pass at once.
module epw_deadband (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       req,
    input  wire logic [6:0] delay,
    output logic            act
);

    epw_pkg::epw_db_t s_reg;
    epw_pkg::epw_db_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.req_d = req;
        if (!req) begin
            s_next.cnt = 7'h00;
            s_next.act = 1'b0;
        end else if (!s_reg.req_d) begin
            s_next.cnt = delay;
            s_next.act = (delay == 7'h00);
        end else if (s_reg.cnt != 7'h00) begin
            s_next.cnt = s_reg.cnt - 7'h01;
            s_next.act = (s_reg.cnt == 7'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign act = s_reg.act;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_fall_fast;
        !req |=> !act;
    endproperty
    a_fall_fast: assert property (p_fall_fast) else $error("active output not dropped");

    property p_delay_three;
        ($rose(req) && delay == 7'h03) ##1 req [*3] |=> act && !$past(act, 1);
    endproperty
    a_delay_three: assert property (p_delay_three) else $error("dead band not three cycles");

    property p_short_pulse;
        ($rose(req) && delay == 7'h05) ##1 !req |-> !act ##1 !act;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("short pulse leaked out");

endmodule

`default_nettype wire

// File: hdl/epw_output_stage.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module epw_output_stage (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pwm_raw,
    input  wire logic        period_start,
    input  wire logic        ext_int_pin,
    input  wire logic        comparator_one,
    output logic             pwm_out_primary,
    output logic             pwm_out_primary_oe,
    output logic             pwm_out_secondary,
    output logic             pwm_out_secondary_oe
);

    epw_pkg::epw_state_t s_reg;
    epw_pkg::epw_state_t s_next;

    logic       act_a;
    logic       act_b;
    logic [3:0] unit_mode_sel;
    logic [1:0] output_config_sel;
    logic [2:0] shutdown_source_sel;
    logic [1:0] safe_state_pair_a;
    logic [1:0] safe_state_pair_b;
    logic       shutdown_status;
    logic       auto_restart_en;
    logic [6:0] deadband_count;
    logic       steer_sync_sel;
    logic       half_mode;
    logic       single_mode;
    logic       unit_en;
    logic       use_a;
    logic       use_b;
    logic       sd_cond;
    logic       req_b;
    logic [6:0] delay_cyc;

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    assign unit_mode_sel       = s_reg.config_r[epw_pkg::MODE_LSB +: 4];
    assign output_config_sel   = s_reg.config_r[epw_pkg::CFG_SEL_LSB +: 2];
    assign shutdown_status     = s_reg.shutdown_r[epw_pkg::SD_STATUS_BIT];
    assign shutdown_source_sel = s_reg.shutdown_r[epw_pkg::SD_SRC_LSB +: 3];
    assign safe_state_pair_a   = s_reg.shutdown_r[epw_pkg::SAFE_A_LSB +: 2];
    assign safe_state_pair_b   = s_reg.shutdown_r[epw_pkg::SAFE_B_LSB +: 2];
    assign auto_restart_en     = s_reg.deadband_r[epw_pkg::RESTART_BIT];
    assign deadband_count      = s_reg.deadband_r[epw_pkg::DB_COUNT_LSB +: 7];
    assign steer_sync_sel      = s_reg.steering_r[epw_pkg::STEER_SYNC_BIT];

    // Reserved configuration codes leave both pins undriven.
    assign half_mode   = (output_config_sel == epw_pkg::CFG_HALF);
    assign single_mode = (output_config_sel == epw_pkg::CFG_SINGLE);
    assign unit_en     = (unit_mode_sel[3:2] == epw_pkg::MODE_PWM) && (half_mode || single_mode);
    assign use_a       = unit_en && (half_mode || s_reg.steer_eff[0]);
    assign use_b       = unit_en && (half_mode || s_reg.steer_eff[1]);

    // The level is read after the synchroniser, so a trigger reaches the pins in four cycles.
    assign sd_cond = (shutdown_source_sel[epw_pkg::SRC_PIN_BIT] && !s_reg.pin_s2)
                  || (shutdown_source_sel[epw_pkg::SRC_CMP_BIT] && s_reg.cmp_s2);

    // One clock is one instruction cycle, so the count is used as is in half-bridge mode; single output gets no dead band.
    assign req_b     = half_mode ? !pwm_raw : pwm_raw;
    assign delay_cyc = half_mode ? deadband_count : 7'h00;

    // ------------------------------------------------------------
    // Dead-band counters, one per output
    // ------------------------------------------------------------
    epw_deadband u_db_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (pwm_raw),
        .delay   (delay_cyc),
        .act     (act_a)
    );

    epw_deadband u_db_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (req_b),
        .delay   (delay_cyc),
        .act     (act_b)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       do_write;
        logic       sd_next;
        logic       run_on;
        logic [7:0] wd;
        do_write = 1'b0;
        sd_next  = 1'b0;
        run_on   = 1'b0;
        wd       = 8'h00;
        s_next   = s_reg;

        s_next.pin_s1 = ext_int_pin;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.cmp_s1 = comparator_one;
        s_next.cmp_s2 = s_reg.cmp_s1;

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
            s_next.awready = 1'b0;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_hold  = 1'b1;
            s_next.w_data  = s_axi_wdata[7:0];
            s_next.w_lane0 = s_axi_wstrb[0];
            s_next.wready  = 1'b0;
        end
        if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid) begin
            do_write       = s_reg.w_lane0;
            wd             = s_reg.w_data;
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = epw_pkg::RESP_OKAY;
            if (s_reg.aw_addr != epw_pkg::OFS_CONFIG && s_reg.aw_addr != epw_pkg::OFS_SHUTDOWN
                && s_reg.aw_addr != epw_pkg::OFS_DEADBAND
                && s_reg.aw_addr != epw_pkg::OFS_STEERING
                && s_reg.aw_addr != epw_pkg::OFS_STATUS) begin
                s_next.bresp = epw_pkg::RESP_SLVERR;
            end
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid  = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready  = 1'b1;
        end

        // Shutdown status: auto clear, then firmware, then the live condition, which wins.
        sd_next = shutdown_status;
        if (auto_restart_en && !sd_cond) begin
            sd_next = 1'b0;
        end
        if (do_write) begin
            if (s_reg.aw_addr == epw_pkg::OFS_CONFIG) begin
                s_next.config_r = wd;
            end else if (s_reg.aw_addr == epw_pkg::OFS_SHUTDOWN) begin
                s_next.shutdown_r = wd;
                if (sd_cond) begin
                    sd_next = 1'b1;
                end else begin
                    sd_next = wd[epw_pkg::SD_STATUS_BIT];
                end
            end else if (s_reg.aw_addr == epw_pkg::OFS_DEADBAND) begin
                s_next.deadband_r = wd;
            end else if (s_reg.aw_addr == epw_pkg::OFS_STEERING) begin
                s_next.steering_r = wd & 8'h13;
            end
        end
        if (sd_cond) begin
            sd_next = 1'b1;
        end
        s_next.shutdown_r[epw_pkg::SD_STATUS_BIT] = sd_next;

        // Steering takes effect at once or at the next period start.
        if (!steer_sync_sel || period_start) begin
            s_next.steer_eff = {s_reg.steering_r[epw_pkg::STEER_B_BIT],
                                s_reg.steering_r[epw_pkg::STEER_A_BIT]};
        end

        // Output only starts on a period boundary, never mid-cycle.
        case (s_reg.run)
            epw_pkg::EPW_OFF: begin
                if (unit_en) begin
                    s_next.run = epw_pkg::EPW_WAIT;
                end
            end
            epw_pkg::EPW_WAIT: begin
                if (!unit_en) begin
                    s_next.run = epw_pkg::EPW_OFF;
                end else if (period_start && !shutdown_status) begin
                    s_next.run = epw_pkg::EPW_RUN;
                end
            end
            epw_pkg::EPW_RUN: begin
                if (!unit_en) begin
                    s_next.run = epw_pkg::EPW_OFF;
                end else if (shutdown_status) begin
                    s_next.run = epw_pkg::EPW_WAIT;
                end
            end
            default: begin
                s_next.run = epw_pkg::EPW_OFF;
            end
        endcase
        run_on = (s_reg.run == epw_pkg::EPW_RUN) && !shutdown_status;

        // Pins: safe state during shutdown, else the polarised waveform.
        s_next.oe_a = use_a;
        s_next.oe_b = use_b;
        s_next.out_a = (run_on && act_a) ^ unit_mode_sel[1];
        s_next.out_b = (run_on && act_b) ^ unit_mode_sel[0];
        if (shutdown_status && use_a) begin
            s_next.out_a = safe_state_pair_a[0];
            s_next.oe_a  = !safe_state_pair_a[1];
        end
        if (shutdown_status && use_b) begin
            s_next.out_b = safe_state_pair_b[0];
            s_next.oe_b  = !safe_state_pair_b[1];
        end

        // Read channel.
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rresp   = epw_pkg::RESP_OKAY;
            if (s_axi_araddr == epw_pkg::OFS_CONFIG) begin
                s_next.rdata = s_reg.config_r;
            end else if (s_axi_araddr == epw_pkg::OFS_SHUTDOWN) begin
                s_next.rdata = s_reg.shutdown_r;
            end else if (s_axi_araddr == epw_pkg::OFS_DEADBAND) begin
                s_next.rdata = s_reg.deadband_r;
            end else if (s_axi_araddr == epw_pkg::OFS_STEERING) begin
                s_next.rdata = s_reg.steering_r;
            end else if (s_axi_araddr == epw_pkg::OFS_STATUS) begin
                s_next.rdata = {2'h0, s_reg.oe_b, s_reg.oe_a, s_reg.out_b, s_reg.out_a,
                                run_on, sd_cond};
            end else begin
                s_next.rdata = 8'h00;
                s_next.rresp = epw_pkg::RESP_SLVERR;
            end
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg            <= '0;
            s_reg.awready    <= 1'b1;
            s_reg.wready     <= 1'b1;
            s_reg.arready    <= 1'b1;
            s_reg.config_r   <= epw_pkg::RST_CONFIG;
            s_reg.shutdown_r <= epw_pkg::RST_SHUTDOWN;
            s_reg.deadband_r <= epw_pkg::RST_DEADBAND;
            s_reg.steering_r <= epw_pkg::RST_STEERING;
            s_reg.steer_eff  <= 2'h1;
            s_reg.pin_s1     <= 1'b1;
            s_reg.pin_s2     <= 1'b1;
            s_reg.run        <= epw_pkg::EPW_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready        = s_reg.awready;
    assign s_axi_wready         = s_reg.wready;
    assign s_axi_bvalid         = s_reg.bvalid;
    assign s_axi_bresp          = s_reg.bresp;
    assign s_axi_arready        = s_reg.arready;
    assign s_axi_rvalid         = s_reg.rvalid;
    assign s_axi_rresp          = s_reg.rresp;
    assign s_axi_rdata          = {24'h000000, s_reg.rdata};
    assign pwm_out_primary      = s_reg.out_a;
    assign pwm_out_primary_oe   = s_reg.oe_a;
    assign pwm_out_secondary    = s_reg.out_b;
    assign pwm_out_secondary_oe = s_reg.oe_b;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic run_on_chk;
    logic do_wr_chk;
    assign run_on_chk = (s_reg.run == epw_pkg::EPW_RUN) && !shutdown_status;
    assign do_wr_chk  = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_no_overlap;
        (half_mode && $past(half_mode) && $past(half_mode, 2)) |-> !(act_a && act_b);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both outputs active");

    property p_primary_follows;
        (run_on_chk && half_mode) |=> pwm_out_primary == ($past(act_a) ^ $past(unit_mode_sel[1]));
    endproperty
    a_primary_follows: assert property (p_primary_follows) else $error("primary wrong");

    property p_cond_sets;
        sd_cond |=> shutdown_status;
    endproperty
    a_cond_sets: assert property (p_cond_sets) else $error("status not set");

    property p_cond_holds;
        sd_cond [*2] |=> shutdown_status && s_reg.run != epw_pkg::EPW_RUN;
    endproperty
    a_cond_holds: assert property (p_cond_holds) else $error("shutdown released");

    property p_auto_clear;
        (shutdown_status && auto_restart_en && !sd_cond && !do_wr_chk) |=> !shutdown_status;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto restart missed");

    property p_resume_at_period;
        $rose(s_reg.run == epw_pkg::EPW_RUN) |-> $past(period_start);
    endproperty
    a_resume_at_period: assert property (p_resume_at_period) else $error("mid-period start");

    property p_safe_a;
        (shutdown_status && use_a) |=> pwm_out_primary_oe == !$past(safe_state_pair_a[1])
            && (!pwm_out_primary_oe || pwm_out_primary == $past(safe_state_pair_a[0]));
    endproperty
    a_safe_a: assert property (p_safe_a) else $error("primary safe state wrong");

    property p_unsteered;
        (single_mode && !s_reg.steer_eff[1]) |=> !pwm_out_secondary_oe;
    endproperty
    a_unsteered: assert property (p_unsteered) else $error("unsteered pin driven");

    property p_steer_now;
        (!steer_sync_sel && !do_wr_chk) |=> s_reg.steer_eff == $past({s_reg.steering_r[1],
                                                                     s_reg.steering_r[0]});
    endproperty
    a_steer_now: assert property (p_steer_now) else $error("steering late");

    c_half_run: cover property (half_mode && run_on_chk && act_b ##1 act_a);
    c_shutdown: cover property (sd_cond ##3 pwm_out_primary_oe);
    c_auto_restart: cover property (shutdown_status && auto_restart_en ##1 !shutdown_status);
    c_steer_both: cover property (single_mode && s_reg.steer_eff == 2'h3 && run_on_chk);

endmodule

`default_nettype wire

// File: tb/epw_switch_model.sv
`timescale 1ns/10ps
`default_nettype none

// Gate inputs of the two power switches; each input has a pull-down, so an
// undriven pin keeps its switch off.
module epw_switch_model (
    input  wire logic primary,
    input  wire logic primary_oe,
    input  wire logic secondary,
    input  wire logic secondary_oe,
    output logic      hi_on,
    output logic      lo_on
);
    assign hi_on = primary_oe ? primary : 1'b0;
    assign lo_on = secondary_oe ? secondary : 1'b0;
endmodule

`default_nettype wire

// File: tb/enhanced_pwm_output_stage_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module enhanced_pwm_output_stage_tb_top;
    logic        aclk = 0, aresetn = 0, pwm_raw = 0, period_start = 0;
    logic        ext_int_pin = 1, comparator_one = 0, hi_on, lo_on;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, d, w;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h8f82396d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        pwm_out_primary, pwm_out_primary_oe, pwm_out_secondary, pwm_out_secondary_oe;
    int          miscompares = 0, comparisons = 0;
    integer      n;
    logic [1:0]  br;

    epw_output_stage dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_raw, .period_start, .ext_int_pin,
        .comparator_one, .pwm_out_primary, .pwm_out_primary_oe, .pwm_out_secondary,
        .pwm_out_secondary_oe);
    epw_switch_model sw (.primary(pwm_out_primary), .primary_oe(pwm_out_primary_oe),
        .secondary(pwm_out_secondary), .secondary_oe(pwm_out_secondary_oe), .hi_on, .lo_on);

    initial forever #4 aclk = ~aclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // A pulse shorter than the dead band never reaches the pin.
    function automatic logic [31:0] on_cycles(input logic [7:0] w, input logic [7:0] d);
        return (w > d) ? w - d : 32'h0;
    endfunction

    task automatic print_verdict;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic pulse;
        period_start <= 1;
        @(posedge aclk);
        period_start <= 0;
    endtask

    // ------------------------------------------------------------
    // Bus cycles; a lost answer counts as a mismatch and ends the run.
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int i;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                br = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 0;
        if (i == 40) begin
            miscompares++;
            print_verdict();
        end
        @(posedge aclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [9:0] exp);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        if (i == 40) begin
            miscompares++;
            print_verdict();
        end
        chk({s_axi_rresp, s_axi_rdata[7:0]}, exp);
        @(posedge aclk);
    endtask

    initial begin
        tick(3);
        aresetn <= 1;
        @(posedge aclk);
        rchk(8'h0c, 10'h001);
        rchk(8'h20, 10'h200);
        wr(8'h00, 8'h8c);
        tick(3);
        chk(pwm_out_secondary, 0);
        pulse();
        for (int j = 0; j < 7; j++) begin
            seed = lfsr(seed);
            d = (j == 0) ? 8'd5 : {5'h0, seed[2:0]};
            w = (j == 0) ? 8'd5 : {4'h0, seed[7:4]} + 8'd1;
            wr(8'h08, d);
            tick(12);
            chk(pwm_out_secondary, 1);
            pwm_raw <= 1;
            n = 0;
            for (int k = 0; k < w + d + 8; k++) begin
                @(posedge aclk);
                if (k == w - 1) pwm_raw <= 0;
                #1 n += pwm_out_primary;
            end
            chk(n, on_cycles(w, d));
        end
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h14);
        comparator_one <= 1;
        tick(6);
        chk({hi_on, lo_on, pwm_out_primary_oe, pwm_out_secondary_oe}, 4'hb);
        rchk(8'h04, 10'h094);
        wr(8'h04, 8'h14);
        chk(br, 2'h0);
        rchk(8'h04, 10'h094);
        comparator_one <= 0;
        pwm_raw <= 1;
        tick(6);
        rchk(8'h04, 10'h094);
        wr(8'h04, 8'h14);
        tick(6);
        chk(pwm_out_primary, 0);
        pulse();
        tick(6);
        chk(pwm_out_primary, 1);
        wr(8'h08, 8'h80);
        wr(8'h04, 8'h44);
        ext_int_pin <= 0;
        tick(6);
        rchk(8'h04, 10'h0c4);
        ext_int_pin <= 1;
        tick(6);
        rchk(8'h04, 10'h044);
        wr(8'h00, 8'h0e);
        wr(8'h0c, 8'h03);
        pulse();
        tick(6);
        chk({pwm_out_primary, pwm_out_secondary}, 2'b01);
        wr(8'h0c, 8'h02);
        tick(3);
        chk(pwm_out_primary_oe, 0);
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h84);
        tick(2);
        chk({pwm_out_primary_oe, pwm_out_secondary_oe, pwm_out_secondary}, 3'b010);
        rchk(8'h04, 10'h084);
        wr(8'h04, 8'h04);
        tick(2);
        chk(pwm_out_secondary, 0);
        pulse();
        tick(3);
        chk(pwm_out_secondary, 1);
        wr(8'h0c, 8'h13);
        tick(3);
        chk(pwm_out_primary_oe, 0);
        pulse();
        tick(3);
        chk(pwm_out_primary_oe, 1);
        wr(8'h00, 8'h4e);
        tick(2);
        chk({pwm_out_primary_oe, pwm_out_secondary_oe}, 2'b00);
        wr(8'h20, 8'hff);
        chk(br, 2'h2);
        print_verdict();
    end
endmodule

`default_nettype wire
